// ### mwd_cfg.svh
`ifndef MWD_CFG_SVH
`define MWD_CFG_SVH
// Register indices, byte address is four times the index
`define MWD_IDX_POWER 8'h10
`define MWD_IDX_CTRL 8'h13
`define MWD_IDX_CFG 8'h14
`define MWD_IDX_STAT 8'h18
`define MWD_IDX_MASK 8'h19
`define MWD_ADDR_POWER 8'h40
`define MWD_ADDR_CTRL 8'h4C
`define MWD_ADDR_CFG 8'h50
`define MWD_ADDR_STAT 8'h60
`define MWD_ADDR_MASK 8'h64
// Control register fields
`define MWD_CTRL_MODE 7
`define MWD_CTRL_COMB 6
`define MWD_CTRL_DATA_HI 5
// Configuration register fields
`define MWD_CFG_RESET 7
`define MWD_CFG_SLICE_HI 6
`define MWD_CFG_SLICE_LO 4
`define MWD_CFG_CNTEN 3
// Power register axis power-down field
`define MWD_PD_HI 6
`define MWD_PD_LO 4
// Reset values
`define MWD_RST_REG8 8'h00
`define MWD_RST_PARAM 6'h00
`define MWD_RST_STAT4 4'h0
// Highest slice step
`define MWD_SLICE_MAX 3'h5
`endif

// ### mwd_pkg.sv
package mwd_pkg;
  // Shadow register pointer codes
  typedef enum logic [2:0] {
    MWD_SEL_NONE0 = 3'b000,
    MWD_SEL_THR_X = 3'b001,
    MWD_SEL_THR_Y = 3'b010,
    MWD_SEL_THR_Z = 3'b011,
    MWD_SEL_NONE1 = 3'b100,
    MWD_SEL_CNT_X = 3'b101,
    MWD_SEL_CNT_Y = 3'b110,
    MWD_SEL_CNT_Z = 3'b111
  } mwd_sel_e;
  typedef logic [5:0] mwd_param_t;
  typedef logic [10:0] mwd_delta_t;
endpackage

// ### mwd_top.sv
`timescale 1ns/1ps
`include "mwd_cfg.svh"
// Behaviour
// - Each axis forms a delta per sample and detects only when it is strictly above the threshold.
// - Each axis has its own unsigned 6-bit threshold, written without touching the others.
// - An optional per-axis detection counter delays the axis wakeup past the first detection.
// - A count field holds the wanted number of events minus one, so zero means one event.
// - The shadow data field reaches the register chosen by the pointer; 000 and 100 reach none.
// - Combine select 0 ORs the active axes and 1 requires every active axis to qualify.
// - An axis with its power-down bit set takes no part in the combination.
// - An axis qualifies only after meeting both its threshold and its count requirement.
// - Control bit 7 picks previous-sample (0, default) or baseline (1) differencing.
// - Previous-sample differencing subtracts the preceding sample of the same axis.
// - Baseline differencing keeps the first sample of the watch mode and subtracts from it.
// - The control register holds method in bit 7, combine in bit 6 and shadow data in 5:0.
// - Detection counts apply only while count enable is 1; otherwise one detection suffices.
// - The slice select picks six bits of the 11-bit delta, 000 for 5:0 up to 10:5 from 101.
// - Configuration bit 7 holds the detector in reset while set and does not clear itself.
module mwd_top #(
  parameter int SAMPLE_W = 12
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Sample stream from acquisition
  input wire logic watch_mode,
  input wire logic sample_valid,
  input wire logic signed [SAMPLE_W-1:0] x_sample,
  input wire logic signed [SAMPLE_W-1:0] y_sample,
  input wire logic signed [SAMPLE_W-1:0] z_sample,
  // Results
  output logic wake,
  output logic irq
);

  logic [7:0] power_ff;
  logic [7:0] ctrl_ff;
  logic [7:0] cfg_ff;
  logic [3:0] stat_ff;
  logic [3:0] mask_ff;
  mwd_pkg::mwd_param_t thr_ff [3];
  mwd_pkg::mwd_param_t cnt_ff [3];
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;
  logic wake_ff;
  logic irq_ff;
  logic [2:0] qual;
  logic [2:0] qual_set;
  logic wake_set;
  logic nxt_wake;
  logic acc;
  logic wr_en;
  logic mapped;
  logic [5:0] shadow_rd;
  logic [1:0] shadow_idx;
  logic det_rst;
  logic [2:0] active;
  logic [2:0] slice_sel;
  mwd_pkg::mwd_sel_e ptr;

  // One wait state so read data comes from a flip-flop
  assign acc = psel & penable;
  assign wr_en = acc & pready_ff & pwrite;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign prdata = prdata_ff;

  // Address decode
  always_comb
  begin
    case (paddr)
      `MWD_ADDR_POWER: mapped = 1'b1;
      `MWD_ADDR_CTRL: mapped = 1'b1;
      `MWD_ADDR_CFG: mapped = 1'b1;
      `MWD_ADDR_STAT: mapped = 1'b1;
      `MWD_ADDR_MASK: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // Pointer into the shadow bank
  assign ptr = mwd_pkg::mwd_sel_e'(cfg_ff[2:0]);
  assign shadow_idx = cfg_ff[1:0] - 2'h1;

  // Shadow read mux, empty codes read zero
  always_comb
  begin
    case (ptr)
      mwd_pkg::MWD_SEL_THR_X: shadow_rd = thr_ff[0];
      mwd_pkg::MWD_SEL_THR_Y: shadow_rd = thr_ff[1];
      mwd_pkg::MWD_SEL_THR_Z: shadow_rd = thr_ff[2];
      mwd_pkg::MWD_SEL_CNT_X: shadow_rd = cnt_ff[0];
      mwd_pkg::MWD_SEL_CNT_Y: shadow_rd = cnt_ff[1];
      mwd_pkg::MWD_SEL_CNT_Z: shadow_rd = cnt_ff[2];
      default: shadow_rd = `MWD_RST_PARAM;
    endcase
  end

  // Access phase handshake
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end
    else
    begin
      pready_ff <= acc & ~pready_ff;
      pslverr_ff <= acc & ~pready_ff & ~mapped;
    end
  end

  // Read data capture
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      prdata_ff <= 32'h0000_0000;
    end
    else if (acc & ~pready_ff & ~pwrite)
    begin
      case (paddr)
        `MWD_ADDR_POWER: prdata_ff <= {24'h000000, power_ff};
        `MWD_ADDR_CTRL: prdata_ff <= {24'h000000, ctrl_ff[7:6], shadow_rd};
        `MWD_ADDR_CFG: prdata_ff <= {24'h000000, cfg_ff};
        `MWD_ADDR_STAT: prdata_ff <= {28'h0000000, stat_ff};
        `MWD_ADDR_MASK: prdata_ff <= {28'h0000000, mask_ff};
        default: prdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  // Plain registers
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      power_ff <= `MWD_RST_REG8;
      ctrl_ff <= `MWD_RST_REG8;
      cfg_ff <= `MWD_RST_REG8;
      mask_ff <= `MWD_RST_STAT4;
    end
    else if (wr_en)
    begin
      case (paddr)
        `MWD_ADDR_POWER: power_ff <= pwdata[7:0];
        `MWD_ADDR_CTRL: ctrl_ff <= {pwdata[7:6], 6'h00};
        `MWD_ADDR_CFG: cfg_ff <= pwdata[7:0];
        `MWD_ADDR_MASK: mask_ff <= pwdata[3:0];
        default: ;
      endcase
    end
  end

  // Shadow bank writes, pointer low bits pick the axis
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      thr_ff <= '{default: `MWD_RST_PARAM};
      cnt_ff <= '{default: `MWD_RST_PARAM};
    end
    else if (wr_en && paddr == `MWD_ADDR_CTRL && cfg_ff[1:0] != 2'h0)
    begin
      if (cfg_ff[2])
      begin
        cnt_ff[shadow_idx] <= pwdata[5:0];
      end
      else
      begin
        thr_ff[shadow_idx] <= pwdata[5:0];
      end
    end
  end

  // Detector held in reset by the sticky bit or outside watch mode
  assign det_rst = cfg_ff[`MWD_CFG_RESET] | ~watch_mode;
  assign active = ~power_ff[`MWD_PD_HI:`MWD_PD_LO];
  always_comb
  begin
    if (cfg_ff[`MWD_CFG_SLICE_HI:`MWD_CFG_SLICE_LO] > `MWD_SLICE_MAX)
    begin
      slice_sel = `MWD_SLICE_MAX;
    end
    else
    begin
      slice_sel = cfg_ff[`MWD_CFG_SLICE_HI:`MWD_CFG_SLICE_LO];
    end
  end

  // Per-axis delta, compare and count
  for (genvar a = 0; a < 3; a++)
  begin : g_axis
    logic signed [SAMPLE_W-1:0] cur;
    logic signed [SAMPLE_W-1:0] prev_ff;
    logic signed [SAMPLE_W-1:0] base_ff;
    logic signed [SAMPLE_W-1:0] refv;
    logic have_prev_ff;
    logic have_base_ff;
    logic [5:0] dcnt_ff;
    logic qual_ff;
    logic signed [SAMPLE_W:0] diff;
    logic [SAMPLE_W:0] mag;
    mwd_pkg::mwd_delta_t delta;
    logic [5:0] slice;
    logic ref_ok;
    logic hit;

    if (a == 0)
    begin : g_x
      assign cur = x_sample;
    end
    else if (a == 1)
    begin : g_y
      assign cur = y_sample;
    end
    else
    begin : g_z
      assign cur = z_sample;
    end

    // Reference from method select
    assign refv = ctrl_ff[`MWD_CTRL_MODE] ? base_ff : prev_ff;
    assign ref_ok = ctrl_ff[`MWD_CTRL_MODE] ? have_base_ff : have_prev_ff;
    assign diff = (SAMPLE_W+1)'(cur) - (SAMPLE_W+1)'(refv);
    assign mag = diff[SAMPLE_W] ? (SAMPLE_W+1)'(-diff) : diff;

    // Saturate magnitude to the 11-bit delta width
    always_comb
    begin
      if (mag > (SAMPLE_W+1)'(11'h7FF))
      begin
        delta = 11'h7FF;
      end
      else
      begin
        delta = mag[10:0];
      end
    end

    assign slice = 6'(delta >> slice_sel);
    assign hit = sample_valid & ref_ok & (slice > thr_ff[a]);

    // Previous sample tracking
    always_ff @(posedge mclk or negedge rstn)
    begin
      if (!rstn)
      begin
        prev_ff <= '0;
        have_prev_ff <= 1'b0;
      end
      else if (det_rst)
      begin
        have_prev_ff <= 1'b0;
      end
      else if (sample_valid)
      begin
        prev_ff <= cur;
        have_prev_ff <= 1'b1;
      end
    end

    // Baseline is the first sample seen in watch mode
    always_ff @(posedge mclk or negedge rstn)
    begin
      if (!rstn)
      begin
        base_ff <= '0;
        have_base_ff <= 1'b0;
      end
      else if (det_rst)
      begin
        have_base_ff <= 1'b0;
      end
      else if (sample_valid && !have_base_ff)
      begin
        base_ff <= cur;
        have_base_ff <= 1'b1;
      end
    end

    // Detection counter; qualification sticks until re-armed
    always_ff @(posedge mclk or negedge rstn)
    begin
      if (!rstn)
      begin
        dcnt_ff <= 6'h00;
        qual_ff <= 1'b0;
      end
      else if (det_rst)
      begin
        dcnt_ff <= 6'h00;
        qual_ff <= 1'b0;
      end
      else if (hit && !qual_ff)
      begin
        if (!cfg_ff[`MWD_CFG_CNTEN] || dcnt_ff >= cnt_ff[a])
        begin
          qual_ff <= 1'b1;
        end
        else
        begin
          dcnt_ff <= dcnt_ff + 6'h01;
        end
      end
    end

    assign qual[a] = qual_ff;
    assign qual_set[a] = hit & ~qual_ff & ~det_rst &
      (~cfg_ff[`MWD_CFG_CNTEN] | (dcnt_ff >= cnt_ff[a]));
  end

  // Combine only the powered axes; none active means no wake
  always_comb
  begin
    if (ctrl_ff[`MWD_CTRL_COMB])
    begin
      nxt_wake = (active != 3'h0) && ((qual | ~active) == 3'h7);
    end
    else
    begin
      nxt_wake = |(qual & active);
    end
  end

  // Wake level, registered
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      wake_ff <= 1'b0;
    end
    else
    begin
      wake_ff <= nxt_wake;
    end
  end

  assign wake_set = nxt_wake & ~wake_ff;
  assign wake = wake_ff;

  // Sticky status, a new event beats a same-cycle clear
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      stat_ff <= `MWD_RST_STAT4;
    end
    else
    begin
      stat_ff <= (stat_ff & ~((wr_en && paddr == `MWD_ADDR_STAT) ? pwdata[3:0] : 4'h0))
        | {qual_set, wake_set};
    end
  end

  // Level interrupt from unmasked status
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      irq_ff <= 1'b0;
    end
    else
    begin
      irq_ff <= |(stat_ff & mask_ff);
    end
  end

  assign irq = irq_ff;

endmodule // mwd_top

// ### mwd_chk_sva.sv
`timescale 1ns/1ps
module mwd_chk (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Detector
  input wire logic watch_mode,
  input wire logic wake,
  input wire logic irq
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  // One wait state, then the answer
  sequence s_wait_ready;
    !pready ##1 pready;
  endsequence
  a_ready_latency: assert property (psel && !penable |=> s_wait_ready)
    else $error("pready not in second access cycle");
  a_ready_single: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  a_idle_ready: assert property (!psel |=> !pready)
    else $error("pready without select");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_err_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  a_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_reset_quiet: assert property ($rose(rstn) |-> !pready && !wake && !irq)
    else $error("output active after reset");
  // Leaving watch mode must drop the wakeup within two edges
  a_wake_clear: assert property (!watch_mode |-> ##2 !wake)
    else $error("wake outside watch mode");
endmodule // mwd_chk
bind mwd_top mwd_chk chk_u (.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .watch_mode(watch_mode), .wake(wake), .irq(irq));

// ### mwd_host.sv
`timescale 1ns/1ps
module mwd_host (
  // Clock
  input wire logic mclk,
  // APB master side
  output logic [7:0] paddr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // Idle bus at time zero
  initial
  begin
    paddr <= 8'h00;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    pwdata <= 32'h0;
  end
  // One transfer; waits on pready, the bench watchdog ends a hang
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    @(posedge mclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1)
      @(posedge mclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule // mwd_host

// ### tb_top.sv
`timescale 1ns/1ps
`include "mwd_cfg.svh"
module tb_top;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic watch_mode = 1'b0;
  logic sample_valid = 1'b0;
  logic signed [11:0] xs = 12'h000;
  logic signed [11:0] ys = 12'h000;
  logic signed [11:0] zs = 12'h000;
  logic [7:0] paddr;
  logic psel, penable, pwrite, pready, pslverr, wake, irq, e;
  logic [31:0] pwdata, prdata, q;
  logic [7:0] ra [5] = '{`MWD_ADDR_POWER, `MWD_ADDR_CTRL, `MWD_ADDR_CFG, `MWD_ADDR_STAT,
    `MWD_ADDR_MASK};
  int err_count = 0;
  int cmp_count = 0;
  always #5 mclk = ~mclk;
  mwd_host host_u (.mclk(mclk), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  mwd_top #(.SAMPLE_W(12)) dut_u (.mclk(mclk), .rstn(rstn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .watch_mode(watch_mode), .sample_valid(sample_valid),
    .x_sample(xs), .y_sample(ys), .z_sample(zs), .wake(wake), .irq(irq));
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    cmp_count++;
    if (s !== x)
    begin
      err_count++;
      $display("unexpected %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host_u.xfer(a, 1'b1, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    host_u.xfer(a, 1'b0, 32'h0, q, e);
    chk("rdata", q, x);
  endtask
  // Y sees the opposite sign so both directions get exercised
  task automatic smp(input logic signed [11:0] v);
    @(posedge mclk);
    sample_valid <= 1'b1;
    xs <= v;
    ys <= -v;
    zs <= v;
    @(posedge mclk);
    sample_valid <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Watchdog well past the expected run time
  initial
  begin
    #100000;
    err_count++;
    stop_test();
  end
  initial
  begin
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    foreach (ra[i]) rd(ra[i], 32'h0);
    host_u.xfer(8'h44, 1'b0, 32'h0, q, e);
    chk("slverr", e, 32'h1);
    for (int p = 1; p < 8; p++)
      if (p != 4)
      begin
        wr(`MWD_ADDR_CFG, p);
        wr(`MWD_ADDR_CTRL, p * 7);
      end
    for (int p = 1; p < 8; p++)
      if (p != 4)
      begin
        wr(`MWD_ADDR_CFG, p);
        rd(`MWD_ADDR_CTRL, p * 7);
      end
    wr(`MWD_ADDR_CFG, 8'h00);
    wr(`MWD_ADDR_CTRL, 8'hFF);
    rd(`MWD_ADDR_CTRL, 8'hC0);
    wr(`MWD_ADDR_CFG, 8'h04);
    rd(`MWD_ADDR_CTRL, 8'hC0);
    wr(`MWD_ADDR_CFG, 8'h01);
    rd(`MWD_ADDR_CTRL, 8'hC7);
    wr(`MWD_ADDR_CTRL, 8'h0A);
    wr(`MWD_ADDR_CFG, 8'h02);
    wr(`MWD_ADDR_CTRL, 8'h3F);
    wr(`MWD_ADDR_CFG, 8'h03);
    wr(`MWD_ADDR_CTRL, 8'h3F);
    wr(`MWD_ADDR_CFG, 8'h00);
    watch_mode <= 1'b1;
    // Equal delta on X rising must not hit, one above on X falling must
    smp(12'sd0);
    smp(12'sd10);
    chk("wake", wake, 32'h0);
    smp(-12'sd1);
    chk("wake", wake, 32'h1);
    rd(`MWD_ADDR_STAT, 32'h3);
    chk("irq", irq, 32'h0);
    wr(`MWD_ADDR_MASK, 32'h1);
    repeat (2) @(posedge mclk);
    chk("irq", irq, 32'h1);
    wr(`MWD_ADDR_STAT, 32'hF);
    repeat (2) @(posedge mclk);
    chk("irq", irq, 32'h0);
    rd(`MWD_ADDR_STAT, 32'h0);
    // Re-arm, then three events needed with count two
    wr(`MWD_ADDR_CFG, 8'h85);
    // Qual clears one edge after the write, wake one edge later
    repeat (3) @(posedge mclk);
    chk("wake", wake, 32'h0);
    rd(`MWD_ADDR_CFG, 8'h85);
    wr(`MWD_ADDR_CTRL, 8'h02);
    wr(`MWD_ADDR_CFG, 8'h0D);
    smp(12'sd0);
    smp(12'sd20);
    smp(12'sd0);
    chk("wake", wake, 32'h0);
    smp(12'sd20);
    chk("wake", wake, 32'h1);
    // AND waits for Y and Z until they are powered down
    wr(`MWD_ADDR_CFG, 8'h80);
    wr(`MWD_ADDR_CTRL, 8'h40);
    wr(`MWD_ADDR_CFG, 8'h00);
    smp(12'sd0);
    smp(12'sd20);
    chk("wake", wake, 32'h0);
    wr(`MWD_ADDR_POWER, 8'h60);
    repeat (3) @(posedge mclk);
    chk("wake", wake, 32'h1);
    // Baseline with slice one: only the offset from the first sample hits
    wr(`MWD_ADDR_POWER, 8'h00);
    wr(`MWD_ADDR_CFG, 8'h81);
    wr(`MWD_ADDR_CTRL, 8'h8A);
    wr(`MWD_ADDR_CFG, 8'h10);
    smp(12'sd0);
    smp(12'sd20);
    chk("wake", wake, 32'h0);
    smp(12'sd22);
    chk("wake", wake, 32'h1);
    // Leaving watch mode drops wake; re-entry must take a fresh baseline
    watch_mode <= 1'b0;
    repeat (3) @(posedge mclk);
    chk("wake", wake, 32'h0);
    watch_mode <= 1'b1;
    smp(12'sd40);
    smp(12'sd42);
    chk("wake", wake, 32'h0);
    stop_test();
  end
endmodule // tb_top
